// File: inc/cpe_pkg.sv
// Constants, codes and types of the event selection block.
// Assumes a single core clock; all event inputs are on that clock.
`default_nettype none
package cpe_pkg;
   // ----------------------------------------------------------------
   // Sizes and types
   // ----------------------------------------------------------------
   localparam int NCNT  = 2;
   localparam int NCOND = 35;
   localparam int EVT_W = 9;
   typedef logic [EVT_W-1:0] cpe_evt_t;
   typedef logic [1:0]       cpe_inc_t;
   // ----------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------
   localparam logic [11:0] OFF_CTL0 = 12'h000;
   localparam logic [11:0] OFF_CTL1 = 12'h004;
   localparam logic [11:0] OFF_CNT0 = 12'h008;
   localparam logic [11:0] OFF_CNT1 = 12'h00c;
   localparam int CTL_EVT_LSB  = 0;
   localparam int CTL_MASK_LSB = 16;
   localparam int CTL_EDGE_BIT = 24;
   localparam int CTL_EN_BIT   = 25;
   localparam logic [31:0] CTL_RST = 32'h0000_0000;
   localparam logic [31:0] CNT_RST = 32'h0000_0000;
   // ----------------------------------------------------------------
   // Event select codes
   // ----------------------------------------------------------------
   localparam cpe_evt_t EV_L2_REQ     = 9'h07d;
   localparam cpe_evt_t EV_L2_MISS    = 9'h07e;
   localparam cpe_evt_t EV_L2_FILL    = 9'h07f;
   localparam cpe_evt_t EV_DIRC_MISS  = 9'h162;
   localparam cpe_evt_t EV_IC_FETCH   = 9'h080;
   localparam cpe_evt_t EV_IC_MISS    = 9'h081;
   localparam cpe_evt_t EV_IC_RF_L2   = 9'h082;
   localparam cpe_evt_t EV_IC_RF_SYS  = 9'h083;
   localparam cpe_evt_t EV_ITLB_MISS  = 9'h085;
   localparam cpe_evt_t EV_RS_HIT     = 9'h088;
   localparam cpe_evt_t EV_RS_OVF     = 9'h089;
   localparam cpe_evt_t EV_IC_INVAL   = 9'h08c;
   localparam cpe_evt_t EV_RET_INSN   = 9'h0c0;
   localparam cpe_evt_t EV_RET_MISP   = 9'h0c3;
   localparam cpe_evt_t EV_RET_FP     = 9'h0cb;
   localparam cpe_evt_t EV_IMASK      = 9'h0cd;
   localparam cpe_evt_t EV_IMASK_PEND = 9'h0ce;
   localparam cpe_evt_t EV_INT_TAKEN  = 9'h0cf;
   localparam cpe_evt_t EV_FP_EXC     = 9'h0db;
   // ----------------------------------------------------------------
   // Sub-condition positions in the condition vector
   // ----------------------------------------------------------------
   localparam int C_L2REQ_IC  = 0;
   localparam int C_L2REQ_DC  = 1;
   localparam int C_L2REQ_SNP = 2;
   localparam int C_L2MISS_IC = 3;
   localparam int C_L2MISS_DC = 4;
   localparam int C_L2_VICT   = 5;
   localparam int C_L2_WB     = 6;
   localparam int C_DIRC_LSB  = 7;
   localparam int C_ICF       = 13;
   localparam int C_ICM       = 14;
   localparam int C_ICR_L2    = 15;
   localparam int C_ICR_SYS   = 16;
   localparam int C_ITLB_4K   = 17;
   localparam int C_ITLB_2M   = 18;
   localparam int C_RS_HIT    = 19;
   localparam int C_RS_OVF    = 20;
   localparam int C_INV_LDST  = 21;
   localparam int C_INV_BUS   = 22;
   localparam int C_RET_INS   = 23;
   localparam int C_RET_EXC   = 24;
   localparam int C_BR_MISP   = 25;
   localparam int C_FAR       = 26;
   localparam int C_RESYNC    = 27;
   localparam int C_FP_X87    = 28;
   localparam int C_FP_SSE    = 29;
   localparam int C_IMASK     = 30;
   localparam int C_IMASK_PND = 31;
   localparam int C_HW_INT    = 32;
   localparam int C_FPX_RECL  = 33;
   localparam int C_FPX_TRAP  = 34;
endpackage
`default_nettype wire

// File: inc/cpe_sel_if.sv
// Selection and increment between a counter slot and its qualifier.
// Assumes both ends run on the same clock.
`default_nettype none
interface cpe_sel_if;
   import cpe_pkg::*;
   cpe_evt_t   evt;
   logic [7:0] mask;
   logic       edge_cnt;
   cpe_inc_t   inc;
   modport ctl  (output evt, output mask, output edge_cnt, input inc);
   modport qual (input evt, input mask, input edge_cnt, output inc);
endinterface
`default_nettype wire

// File: rtl/cpe_evt_qual.sv
// Event qualifier for one counter slot: code, mask and edge mode.
// Assumes condition inputs are single-clock-domain signals.
`default_nettype none
module cpe_evt_qual (
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   input  wire logic [cpe_pkg::NCOND-1:0] cond,
   cpe_sel_if.qual                        sel
);
   import cpe_pkg::*;

   logic [7:0]       m;
   logic [NCOND-1:0] c;
   cpe_inc_t         occ;
   logic             prev;
   logic             next_prev;

   assign m = sel.mask;
   assign c = cond;

   // Any selected sub-condition counts once
   function automatic logic pick(input logic [7:0] mk,
                                 input logic [7:0] hits);
      return |(mk & hits);
   endfunction

   // ----------------------------------------------------------------
   // Occurrence decode
   // ----------------------------------------------------------------
   // RL20 one count, reserved ignored
   always_comb begin
      occ = 2'h0;
      unique case (sel.evt)
         EV_L2_REQ: occ = {1'b0, pick(m, {4'h0, c[C_L2REQ_SNP], 1'b0,
                                          c[C_L2REQ_DC], c[C_L2REQ_IC]})};
         EV_L2_MISS: occ = {1'b0, pick(m, {6'h00, c[C_L2MISS_DC],
                                           c[C_L2MISS_IC]})};
         EV_L2_FILL: occ = {1'b0, pick(m, {6'h00, c[C_L2_WB],
                                           c[C_L2_VICT]})};
         EV_DIRC_MISS: occ = {1'b0, pick(m, {1'b0, c[C_DIRC_LSB+3 +: 3],
                                             1'b0, c[C_DIRC_LSB +: 3]})};
         EV_IC_FETCH:   occ = {1'b0, c[C_ICF]};
         EV_IC_MISS:    occ = {1'b0, c[C_ICM]};
         EV_IC_RF_L2:   occ = {1'b0, c[C_ICR_L2]};
         EV_IC_RF_SYS:  occ = {1'b0, c[C_ICR_SYS]};
         EV_ITLB_MISS: occ = {1'b0, pick(m, {6'h00, c[C_ITLB_2M],
                                             c[C_ITLB_4K]})};
         EV_RS_HIT:     occ = {1'b0, c[C_RS_HIT]};
         EV_RS_OVF:     occ = {1'b0, c[C_RS_OVF]};
         EV_IC_INVAL: occ = {1'b0, pick(m, {6'h00, c[C_INV_BUS],
                                            c[C_INV_LDST]})};
         // RL13 exception adds its own one
         EV_RET_INSN: occ = {1'b0, c[C_RET_INS]} + {1'b0, c[C_RET_EXC]};
         // RL14 unpredicted kinds in, resync out
         EV_RET_MISP: occ = {1'b0, (c[C_BR_MISP] & ~c[C_RESYNC])
                                   | c[C_FAR] | c[C_RET_EXC]};
         EV_RET_FP: occ = {1'b0, pick(m, {6'h00, c[C_FP_SSE],
                                          c[C_FP_X87]})};
         EV_IMASK:      occ = {1'b0, c[C_IMASK]};
         EV_IMASK_PEND: occ = {1'b0, c[C_IMASK_PND]};
         EV_INT_TAKEN:  occ = {1'b0, c[C_HW_INT]};
         EV_FP_EXC: occ = {1'b0, pick(m, {4'h0, c[C_FPX_TRAP],
                                          c[C_FPX_RECL], 2'h0})};
         default:       occ = 2'h0;
      endcase
   end

   // ----------------------------------------------------------------
   // Edge counting
   // ----------------------------------------------------------------
   // RL16 edge mode counts entries
   always_comb begin
      next_prev = |occ;
      sel.inc   = sel.edge_cnt ? {1'b0, next_prev & ~prev} : occ;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev <= 1'b0;
      end else begin
         prev <= next_prev;
      end
   end
endmodule
`default_nettype wire

// File: rtl/cpe_top.sv
// Core performance event selection: two counters behind AHB-Lite.
// Assumes event inputs come from core logic on hclk.
//
// Behaviour
// RL1: L2 requests: snoop bit3, dc bit1, ic bit0
// RL2: L2 misses: dc bit1, ic bit0
// RL3: L2 fills bit0, writebacks bit1, per line
// RL4: Directory cache misses: guest 6..4, host 2..0
// RL5: Instruction cache events count speculative activity
// RL6: Fetch count per 32-byte decoder delivery
// RL7: Instruction cache miss per line refill
// RL8: Separate refill counts: L2, system
// RL9: Instruction TLB misses: 2M bit1, 4K bit0
// RL10: Return stack hits from non-empty stack
// RL11: Return stack overflows counted per call
// RL12: Invalidations: bus unit bit1, load/store bit0
// RL13: Retired instructions; exception counts one
// RL14: Mispredicts include unpredicted transfers, exclude resyncs
// RL15: Retired floating point: SSE bit1, x87 bit0
// RL16: Masked-interrupt cycles, or entries in edge mode
// RL17: Masked cycles with pending interrupt
// RL18: Hardware interrupts taken, not software ones
// RL19: FP exceptions: microtrap bit3, reclass bit2
// RL20: Selected sub-conditions OR together; reserved ignored
`default_nettype none
module cpe_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic        hreadyout,
   output var  logic        hresp,
   output var  logic [31:0] hrdata,
   input  wire logic        l2_req_ic,
   input  wire logic        l2_req_dc,
   input  wire logic        l2_req_snoop,
   input  wire logic        l2_miss_ic,
   input  wire logic        l2_miss_dc,
   input  wire logic        l2_fill_victim,
   input  wire logic        l2_wb_system,
   input  wire logic [5:0]  page_directory_cache_miss,
   input  wire logic        ic_fetch_deliver,
   input  wire logic        ic_miss,
   input  wire logic        ic_refill_l2,
   input  wire logic        ic_refill_system,
   input  wire logic        itlb_miss_4k,
   input  wire logic        itlb_miss_2m,
   input  wire logic        ret_stack_hit,
   input  wire logic        ret_stack_overflow,
   input  wire logic        ic_inval_load_store_unit,
   input  wire logic        ic_inval_bus_unit,
   input  wire logic        retire_insn,
   input  wire logic        retire_exc_int,
   input  wire logic        retire_br_mispredict,
   input  wire logic        retire_far_xfer,
   input  wire logic        retire_resync,
   input  wire logic        retire_fp_x87,
   input  wire logic        retire_fp_sse,
   input  wire logic        interrupt_enable_flag,
   input  wire logic        intr_pending,
   input  wire logic        hw_intr_taken,
   input  wire logic        fp_microtrap,
   input  wire logic        fp_reclass
);
   import cpe_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [NCOND-1:0] cond;
   logic [3:0]       aph_sel;
   logic             aph_go;
   logic             dph_wr;
   logic [3:0]       dph_sel;
   logic             next_dph_wr;
   logic [3:0]       next_dph_sel;
   logic [31:0]      next_hrdata;
   logic [31:0]      ctl      [NCNT];
   logic [31:0]      cnt      [NCNT];
   logic [31:0]      next_ctl [NCNT];
   logic [31:0]      next_cnt [NCNT];
   cpe_inc_t         inc      [NCNT];

   // One-hot register decode of a byte address
   function automatic logic [3:0] reg_dec(input logic [31:0] a);
      logic [3:0] d;
      d    = 4'h0;
      if (a[31:12] == 20'h00000) begin
         d[0] = (a[11:0] == OFF_CTL0);
         d[1] = (a[11:0] == OFF_CTL1);
         d[2] = (a[11:0] == OFF_CNT0);
         d[3] = (a[11:0] == OFF_CNT1);
      end
      return d;
   endfunction

   // ----------------------------------------------------------------
   // Condition vector
   // ----------------------------------------------------------------
   always_comb begin
      cond = '0;
      // RL1 request sources
      cond[C_L2REQ_IC]  = l2_req_ic;
      cond[C_L2REQ_DC]  = l2_req_dc;
      cond[C_L2REQ_SNP] = l2_req_snoop;
      // RL2 miss sources
      cond[C_L2MISS_IC] = l2_miss_ic;
      cond[C_L2MISS_DC] = l2_miss_dc;
      // RL3 one pulse per 64-byte line
      cond[C_L2_VICT]   = l2_fill_victim;
      cond[C_L2_WB]     = l2_wb_system;
      // RL4 guest in upper three, host lower
      cond[C_DIRC_LSB +: 6] = page_directory_cache_miss;
      // RL5 wrong-path fetch activity kept
      // RL6 one pulse per 32-byte delivery
      cond[C_ICF]       = ic_fetch_deliver;
      // RL7 fetch and prefetch misses
      cond[C_ICM]       = ic_miss;
      // RL8 refill source kept apart
      cond[C_ICR_L2]    = ic_refill_l2;
      cond[C_ICR_SYS]   = ic_refill_system;
      // RL9 page size of missing fetch
      cond[C_ITLB_4K]   = itlb_miss_4k;
      cond[C_ITLB_2M]   = itlb_miss_2m;
      // RL10 speculative returns included
      cond[C_RS_HIT]    = ret_stack_hit;
      // RL11 oldest entry dropped by stack
      cond[C_RS_OVF]    = ret_stack_overflow;
      // RL12 probe source
      cond[C_INV_LDST]  = ic_inval_load_store_unit;
      cond[C_INV_BUS]   = ic_inval_bus_unit;
      cond[C_RET_INS]   = retire_insn;
      cond[C_RET_EXC]   = retire_exc_int;
      cond[C_BR_MISP]   = retire_br_mispredict;
      cond[C_FAR]       = retire_far_xfer;
      cond[C_RESYNC]    = retire_resync;
      // RL15 retired floating point class
      cond[C_FP_X87]    = retire_fp_x87;
      cond[C_FP_SSE]    = retire_fp_sse;
      // RL16 masked while flag is zero
      cond[C_IMASK]     = ~interrupt_enable_flag;
      // RL17 masked and pending
      cond[C_IMASK_PND] = ~interrupt_enable_flag & intr_pending;
      // RL18 hardware interrupts only
      cond[C_HW_INT]    = hw_intr_taken;
      // RL19 assist exception kinds
      cond[C_FPX_TRAP]  = fp_microtrap;
      cond[C_FPX_RECL]  = fp_reclass;
   end

   // ----------------------------------------------------------------
   // Qualifier per counter slot
   // ----------------------------------------------------------------
   for (genvar i = 0; i < NCNT; i++) begin : g_slot
      cpe_sel_if u_if ();
      assign u_if.evt      = ctl[i][CTL_EVT_LSB +: EVT_W];
      assign u_if.mask     = ctl[i][CTL_MASK_LSB +: 8];
      assign u_if.edge_cnt = ctl[i][CTL_EDGE_BIT];
      assign inc[i]        = u_if.inc;
      cpe_evt_qual u_qual (
         .hclk    (hclk),
         .hresetn (hresetn),
         .cond    (cond),
         .sel     (u_if.qual)
      );
   end

   // ----------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // ----------------------------------------------------------------
   assign aph_go  = hsel & htrans[1] & hready;
   assign aph_sel = reg_dec(haddr);

   always_comb begin
      next_dph_wr  = aph_go & hwrite;
      next_dph_sel = aph_go ? aph_sel : 4'h0;
      next_hrdata  = 32'h0000_0000;
      if (aph_go && !hwrite) begin
         unique case (1'b1)
            aph_sel[0]: next_hrdata = ctl[0];
            aph_sel[1]: next_hrdata = ctl[1];
            aph_sel[2]: next_hrdata = cnt[0];
            aph_sel[3]: next_hrdata = cnt[1];
            default:    next_hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_wr    <= 1'b0;
         dph_sel   <= 4'h0;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         dph_wr    <= next_dph_wr;
         dph_sel   <= next_dph_sel;
         hrdata    <= next_hrdata;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Control and counter registers
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NCNT; i++) begin
         next_ctl[i] = ctl[i];
         next_cnt[i] = cnt[i];
         if (ctl[i][CTL_EN_BIT]) begin
            next_cnt[i] = cnt[i] + {30'h0, inc[i]};
         end
         if (dph_wr && dph_sel[i]) begin
            next_ctl[i] = hwdata;
         end
         // Software write beats a same-cycle count
         if (dph_wr && dph_sel[2+i]) begin
            next_cnt[i] = hwdata;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NCNT; i++) begin
            ctl[i] <= CTL_RST;
            cnt[i] <= CNT_RST;
         end
      end else begin
         for (int i = 0; i < NCNT; i++) begin
            ctl[i] <= next_ctl[i];
            cnt[i] <= next_cnt[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks on counter 0
   // ----------------------------------------------------------------
   logic       q0;
   cpe_evt_t   ev0;
   logic [7:0] m0;
   assign q0  = ctl[0][CTL_EN_BIT] & ~ctl[0][CTL_EDGE_BIT]
              & ~(dph_wr & dph_sel[2]);
   assign ev0 = ctl[0][CTL_EVT_LSB +: EVT_W];
   assign m0  = ctl[0][CTL_MASK_LSB +: 8];

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_l2_req_snoop: assert property ( // RL1
      q0 && ev0 == EV_L2_REQ && m0[3] && l2_req_snoop
      |=> cnt[0] == $past(cnt[0]) + 32'h1)
      else $error("snoop request not counted");

   a_l2_miss_dc: assert property ( // RL2
      q0 && ev0 == EV_L2_MISS && m0[1] && l2_miss_dc
      |=> cnt[0] == $past(cnt[0]) + 32'h1)
      else $error("dc miss not counted");

   a_l2_miss_resv: assert property ( // RL20
      q0 && ev0 == EV_L2_MISS && m0[1:0] == 2'h0
      |=> $stable(cnt[0]))
      else $error("reserved mask bits counted");

   a_l2_wb_count: assert property ( // RL3
      q0 && ev0 == EV_L2_FILL && m0[1] && l2_wb_system
      |=> cnt[0] == $past(cnt[0]) + 32'h1)
      else $error("writeback not counted");

   a_dir_guest_l4: assert property ( // RL4
      q0 && ev0 == EV_DIRC_MISS && m0 == 8'h40
      && page_directory_cache_miss == 6'h20
      |=> cnt[0] == $past(cnt[0]) + 32'h1)
      else $error("guest level4 miss not counted");

   a_itlb_2m_only: assert property ( // RL9
      q0 && ev0 == EV_ITLB_MISS && m0 == 8'h01
      && itlb_miss_2m && !itlb_miss_4k
      |=> $stable(cnt[0]))
      else $error("2M miss counted under 4K mask");

   a_retire_sum: assert property ( // RL13
      q0 && ev0 == EV_RET_INSN && retire_insn && retire_exc_int
      |=> cnt[0] == $past(cnt[0]) + 32'h2)
      else $error("exception not added to retired count");

   a_misp_resync: assert property ( // RL14
      q0 && ev0 == EV_RET_MISP && retire_resync
      && !retire_far_xfer && !retire_exc_int
      |=> $stable(cnt[0]))
      else $error("resync counted as mispredict");

   a_imask_edge: assert property ( // RL16
      ctl[0][CTL_EN_BIT] && ctl[0][CTL_EDGE_BIT]
      && !(dph_wr && dph_sel[2]) && ev0 == EV_IMASK
      && $past(!interrupt_enable_flag) && !interrupt_enable_flag
      |=> $stable(cnt[0]))
      else $error("held masked state counted again");

   a_imask_pend: assert property ( // RL17
      q0 && ev0 == EV_IMASK_PEND
      && (interrupt_enable_flag || !intr_pending)
      |=> $stable(cnt[0]))
      else $error("pending cycle counted without both");

   a_fpx_trap: assert property ( // RL19
      q0 && ev0 == EV_FP_EXC && m0[3] && fp_microtrap
      |=> cnt[0] == $past(cnt[0]) + 32'h1)
      else $error("microtrap not counted");

   a_ctl_write: assert property (
      hsel && htrans[1] && hready && hwrite && haddr == 32'h0
      ##1 1'b1 |=> ctl[0] == $past(hwdata))
      else $error("control write lost");
endmodule
`default_nettype wire

// File: testbench/cpe_top_bench.sv
// Self-checking bench for the event selection block.
// Assumes the block is the only AHB-Lite slave; hready is its hreadyout.
`default_nettype none
module cpe_top_bench import cpe_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   // Idle events: interrupt flag set, no pulses
   localparam logic [34:0] IDLE = 35'h0_4000_0000;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [34:0] ev;
   logic [31:0] rdata;
   logic [31:0] preset;
   logic        slot;
   int          errors;
   int          checks;
   // ----------------------------------------------------------------
   // Design
   // ----------------------------------------------------------------
   cpe_top dut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .l2_req_ic(ev[0]), .l2_req_dc(ev[1]), .l2_req_snoop(ev[2]),
      .l2_miss_ic(ev[3]), .l2_miss_dc(ev[4]), .l2_fill_victim(ev[5]),
      .l2_wb_system(ev[6]), .page_directory_cache_miss(ev[12:7]),
      .ic_fetch_deliver(ev[13]), .ic_miss(ev[14]), .ic_refill_l2(ev[15]),
      .ic_refill_system(ev[16]), .itlb_miss_4k(ev[17]),
      .itlb_miss_2m(ev[18]), .ret_stack_hit(ev[19]),
      .ret_stack_overflow(ev[20]), .ic_inval_load_store_unit(ev[21]),
      .ic_inval_bus_unit(ev[22]), .retire_insn(ev[23]),
      .retire_exc_int(ev[24]), .retire_br_mispredict(ev[25]),
      .retire_far_xfer(ev[26]), .retire_resync(ev[27]),
      .retire_fp_x87(ev[28]), .retire_fp_sse(ev[29]),
      .interrupt_enable_flag(ev[30]), .intr_pending(ev[31]),
      .hw_intr_taken(ev[32]), .fp_reclass(ev[33]), .fp_microtrap(ev[34])
   );
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   function automatic logic [34:0] b(input int i);
      return 35'h1 << i;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      if (errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Single word transfer; read data lands in rdata
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {20'h00000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdata = hrdata;
      check({31'h0, hresp}, 32'h0000_0000);
   endtask

   // Select, hold pattern three cycles, stop, read count; slots alternate
   task automatic probe(input cpe_evt_t c, input logic [7:0] m,
                        input logic e, input logic [34:0] p,
                        input logic [31:0] exp);
      logic [11:0] ctl;
      logic [11:0] cnt;
      ctl = slot ? OFF_CTL1 : OFF_CTL0;
      cnt = slot ? OFF_CNT1 : OFF_CNT0;
      bus(1'b1, cnt, preset);
      bus(1'b1, ctl, {6'h00, 1'b1, e, m, 7'h00, c});
      ev <= IDLE ^ p;
      repeat (3) @(posedge hclk);
      ev <= IDLE;
      bus(1'b1, ctl, 32'h0000_0000);
      bus(1'b0, cnt, 32'h0000_0000);
      check(rdata, exp);
      slot = ~slot;
   endtask
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge hclk);
      errors++;
      complete_run();
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      ev = IDLE;
      preset = 32'h0000_0000;
      slot = 1'b0;
      errors = 0;
      checks = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // Reset values, plus one unmapped word
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, 12'(4 * i), 32'h0000_0000);
         check(rdata, 32'h0000_0000);
      end
      bus(1'b1, 12'h010, 32'hffff_ffff);
      bus(1'b0, 12'h010, 32'h0000_0000);
      check(rdata, 32'h0000_0000);
      bus(1'b1, OFF_CTL1, 32'h5a5a_a5a5);
      bus(1'b0, OFF_CTL1, 32'h0000_0000);
      check(rdata, 32'h5a5a_a5a5);
      bus(1'b1, OFF_CTL1, 32'h0000_0000);
      // Count wraps at 32 bits
      preset = 32'hffff_fffe;
      probe(EV_IC_FETCH, 8'h00, 1'b0, b(13), 32'h1);
      preset = 32'h0000_0000;
      probe(EV_L2_REQ, 8'h02, 1'b0, b(1), 32'h3);
      probe(EV_L2_REQ, 8'h08, 1'b0, b(2), 32'h3);
      probe(EV_L2_REQ, 8'h01, 1'b0, b(0), 32'h3);
      probe(EV_L2_REQ, 8'h08, 1'b0, b(0) | b(1), 32'h0);
      probe(EV_L2_REQ, 8'h0b, 1'b0, 35'h7, 32'h3);
      probe(EV_L2_REQ, 8'hf4, 1'b0, 35'h7, 32'h0);
      probe(EV_L2_MISS, 8'h01, 1'b0, b(3), 32'h3);
      probe(EV_L2_MISS, 8'h02, 1'b0, b(4), 32'h3);
      probe(EV_L2_FILL, 8'h01, 1'b0, b(5), 32'h3);
      probe(EV_L2_MISS, 8'hfc, 1'b0, b(3) | b(4), 32'h0);
      probe(EV_L2_FILL, 8'h01, 1'b0, b(6), 32'h0);
      probe(EV_L2_FILL, 8'h02, 1'b0, b(6), 32'h3);
      probe(EV_DIRC_MISS, 8'h10, 1'b0, b(10), 32'h3);
      probe(EV_DIRC_MISS, 8'h40, 1'b0, b(12), 32'h3);
      probe(EV_DIRC_MISS, 8'h04, 1'b0, b(9), 32'h3);
      probe(EV_DIRC_MISS, 8'h01, 1'b0, b(7), 32'h3);
      probe(EV_DIRC_MISS, 8'h40, 1'b0, b(9), 32'h0);
      probe(EV_DIRC_MISS, 8'h88, 1'b0, 35'h1f80, 32'h0);
      probe(EV_IC_FETCH, 8'h00, 1'b0, b(13), 32'h3);
      probe(EV_IC_MISS, 8'h00, 1'b0, b(14), 32'h3);
      probe(EV_IC_RF_L2, 8'h00, 1'b0, b(15), 32'h3);
      probe(EV_IC_RF_SYS, 8'h00, 1'b0, b(16), 32'h3);
      probe(EV_IC_RF_L2, 8'h00, 1'b0, b(16), 32'h0);
      probe(EV_ITLB_MISS, 8'h02, 1'b0, b(18), 32'h3);
      probe(EV_ITLB_MISS, 8'h01, 1'b0, b(17), 32'h3);
      probe(EV_ITLB_MISS, 8'h01, 1'b0, b(18), 32'h0);
      probe(EV_RS_HIT, 8'h00, 1'b0, b(19), 32'h3);
      probe(EV_RS_OVF, 8'h00, 1'b0, b(20), 32'h3);
      probe(EV_IC_INVAL, 8'h02, 1'b0, b(22), 32'h3);
      probe(EV_IC_INVAL, 8'h01, 1'b0, b(21), 32'h3);
      probe(EV_IC_INVAL, 8'h02, 1'b0, b(21), 32'h0);
      probe(EV_RET_INSN, 8'h00, 1'b0, b(23) | b(24), 32'h6);
      probe(EV_RET_INSN, 8'h00, 1'b0, b(23), 32'h3);
      probe(EV_RET_MISP, 8'h00, 1'b0, b(26), 32'h3);
      probe(EV_RET_MISP, 8'h00, 1'b0, b(24), 32'h3);
      probe(EV_RET_MISP, 8'h00, 1'b0, b(25) | b(27), 32'h0);
      probe(EV_RET_MISP, 8'h00, 1'b0, b(25), 32'h3);
      probe(EV_RET_FP, 8'h02, 1'b0, b(29), 32'h3);
      probe(EV_RET_FP, 8'h01, 1'b0, b(28), 32'h3);
      probe(EV_RET_FP, 8'h02, 1'b0, b(28), 32'h0);
      probe(EV_IMASK, 8'h00, 1'b0, b(30), 32'h3);
      probe(EV_IMASK, 8'h00, 1'b1, b(30), 32'h1);
      probe(EV_IMASK_PEND, 8'h00, 1'b0, b(30), 32'h0);
      probe(EV_IMASK_PEND, 8'h00, 1'b0, b(31), 32'h0);
      probe(EV_IMASK_PEND, 8'h00, 1'b0, b(30) | b(31), 32'h3);
      probe(EV_IMASK_PEND, 8'h00, 1'b1, b(30) | b(31), 32'h1);
      probe(EV_INT_TAKEN, 8'h00, 1'b0, b(32), 32'h3);
      probe(EV_INT_TAKEN, 8'h00, 1'b0, b(24), 32'h0);
      probe(EV_FP_EXC, 8'h04, 1'b0, b(33), 32'h3);
      probe(EV_FP_EXC, 8'h08, 1'b0, b(34), 32'h3);
      probe(EV_FP_EXC, 8'h08, 1'b0, b(33), 32'h0);
      probe(EV_FP_EXC, 8'hf3, 1'b0, b(33) | b(34), 32'h0);
      probe(9'h1ff, 8'hff, 1'b0, ~35'h0, 32'h0);
      complete_run();
   end
endmodule
`default_nettype wire
